//--- sscr_defines.vh
`ifndef SSCR_DEFINES_VH
`define SSCR_DEFINES_VH

// ----------------------------------------
// Interrupt codes
// ----------------------------------------
`define SSCR_INT_BUS_RESET 8'h01
`define SSCR_INT_REQ_TMO 8'h2C
`define SSCR_INT_BUS_FREE 8'h31
`define SSCR_INT_PHASE_CHG 8'h32
`define SSCR_INT_BAD_PHASE 8'h54
`define SSCR_INT_MSG_RCVD 8'h55
`define SSCR_INT_STS_RCVD 8'h56
`define SSCR_INT_MSG_SKIP 8'h5D
`define SSCR_INT_STS_SKIP 8'h5E
`define SSCR_INT_DONE 8'h60
`define SSCR_INT_RESEL 8'h64
`define SSCR_INT_NO_COUNT 8'h65
`define SSCR_INT_PAUSE 8'h67
`define SSCR_INT_NEXUS_FREE 8'h70
`define SSCR_INT_SEL_TMO 8'h82

// ----------------------------------------
// Step codes
// ----------------------------------------
`define SSCR_STEP_WAIT_FREE 8'h00
`define SSCR_STEP_ARB 8'h01
`define SSCR_STEP_SEL 8'h02
`define SSCR_STEP_MSG 8'h03
`define SSCR_STEP_DONE_MAN 8'h04
`define SSCR_STEP_DONE_AUTO 8'h0C

// ----------------------------------------
// Bus phases {MSG, C/D, I/O}
// ----------------------------------------
`define SSCR_PH_MSG_OUT 3'h6
`define SSCR_PH_MSG_IN 3'h7
`define SSCR_PH_STATUS 3'h3

// ----------------------------------------
// Limits and reset values
// ----------------------------------------
`define SSCR_SINGLE_MSG_MAX 6'h20
`define SSCR_COUNT_ZERO 8'h00
`define SSCR_BYTE_ZERO 8'h00
`define SSCR_INDEX_ZERO 6'h00
`define SSCR_INDEX_ONE 6'h01
`define SSCR_RETRY_ZERO 4'h0
`define SSCR_RETRY_ONE 4'h1

`endif

//--- sscr_timer.v
`timescale 1ns/1ps
`include "sscr_defines.vh"

module sscr_timer #(
  parameter W = 16
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Control
  input wire load,
  input wire run,
  input wire [W-1:0] limit,
  // Result
  output wire expired
);

  reg [W-1:0] cnt_reg;
  reg [W-1:0] cnt_next;
  wire [W-1:0] zero = {W{1'b0}};
  wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};

  always @* begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = limit;
    end else if (run && cnt_reg != zero) begin
      cnt_next = cnt_reg - one;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= {W{1'b0}};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Not gated by load: that would loop through the caller's next state
  assign expired = run && cnt_reg == zero;

endmodule

//--- sscr_reporter.v
`timescale 1ns/1ps
`include "sscr_defines.vh"

module sscr_reporter (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Report from sequencer
  input wire post,
  input wire [7:0] code,
  input wire [7:0] step,
  // Software side
  input wire int_ack,
  output reg [7:0] int_code_reg,
  output reg [7:0] int_step_reg,
  output reg int_req_reg
);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      int_code_reg <= `SSCR_BYTE_ZERO;
      int_step_reg <= `SSCR_BYTE_ZERO;
      int_req_reg <= 1'b0;
    end else begin
      if (post) begin
        int_code_reg <= code;
        int_step_reg <= step;
      end
      int_req_reg <= post | (int_req_reg & ~int_ack);
    end
  end

endmodule

//--- sscr_sequencer.v
`timescale 1ns/1ps
`include "sscr_defines.vh"

// Summary of operation
// - Reset while awaiting bus free: 01/00
// - Reset during arbitration: 01/01
// - Reset during selection: 01/02
// - Reset in message phase ends immediately: 01/03
// - REQ/ACK timeout stops at once: 2C/03
// - Bus free in message phase after first REQ: 31/03
// - Target phase change mid-message: 32/03
// - Wrong first phase: 54/03, ATN kept
// - Auto receive message in: negate ATN, 55/03
// - Auto receive status: negate ATN, 56/03
// - Message receive, buffer full: skip, 5D/03
// - Status receive, buffer full: skip, 5E/03
// - Normal end, manual ACK release: 60/04
// - Normal end, auto release: drop ACK, 60/0C
// - Lost arbitration then reselected: 64/00
// - Reselection op pending: 64/00 after it completes
// - Single message of 33+ bytes: 64/03
// - Multi-byte count zero: 65/03
// - Pause accepted in arbitration: 67/01
// - Nexus then bus free: 70/03
// - Selection timeout retries, then 82/02
module sscr_sequencer #(
  parameter TW = 16,
  parameter RW = 4
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Command and configuration
  input wire cmd_start,
  input wire cmd_multi,
  input wire [5:0] single_msg_len,
  input wire [7:0] message_byte_count,
  input wire auto_receive,
  input wire auto_ack_release,
  input wire ack_release,
  input wire pause_req,
  input wire [TW-1:0] sel_timeout_limit,
  input wire [TW-1:0] reqack_timeout_limit,
  input wire [RW-1:0] sel_retries,
  // Reselection context
  input wire resel_pending,
  input wire resel_op_done,
  input wire reselected,
  // Arbitration and selection engine
  input wire arb_won,
  input wire arb_lost,
  input wire sel_bsy,
  output wire arb_req,
  output wire sel_req,
  // Target bus
  input wire bus_reset,
  input wire bus_free,
  input wire req_in,
  input wire [2:0] phase_in,
  input wire [7:0] data_in,
  output reg atn_reg,
  output reg ack_reg,
  output reg [7:0] data_out_reg,
  // Message bytes
  input wire [7:0] msg_byte,
  output reg [5:0] msg_index_reg,
  // Receive control byte buffer
  input wire rx_buf_full,
  output reg [7:0] rx_byte_reg,
  output reg rx_wr_reg,
  // Status to software
  input wire int_ack,
  output wire busy,
  output wire [7:0] int_code,
  output wire [7:0] int_step,
  output wire int_req
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE = 10'b0000000001;
  localparam S_RWAIT = 10'b0000000010;
  localparam S_WBF = 10'b0000000100;
  localparam S_ARB = 10'b0000001000;
  localparam S_SEL = 10'b0000010000;
  localparam S_FREQ = 10'b0000100000;
  localparam S_MREQ = 10'b0001000000;
  localparam S_ACK = 10'b0010000000;
  localparam S_RXACK = 10'b0100000000;
  localparam S_HOLD = 10'b1000000000;

  reg [9:0] state_reg;
  reg [9:0] state_next;
  reg [5:0] len_reg;
  reg [5:0] len_next;
  reg [RW-1:0] retry_reg;
  reg [RW-1:0] retry_next;
  reg rx_status_reg;
  reg rx_status_next;
  reg atn_next;
  reg ack_next;
  reg [7:0] data_out_next;
  reg [5:0] msg_index_next;
  reg [7:0] rx_byte_next;
  reg rx_wr_next;
  reg post;
  reg [7:0] rep_code;
  reg [7:0] rep_step;
  wire tmo;
  wire tmr_run;
  wire tmr_load;
  wire [TW-1:0] tmr_limit;
  wire last_byte;
  wire msg_phase;

  assign msg_phase = state_reg == S_FREQ || state_reg == S_MREQ ||
    state_reg == S_ACK || state_reg == S_RXACK;
  assign last_byte = msg_index_reg + `SSCR_INDEX_ONE == len_reg;
  assign busy = state_reg != S_IDLE;
  assign arb_req = state_reg == S_ARB;
  assign sel_req = state_reg == S_SEL;

  // Shared timer: selection window, then REQ/ACK window
  assign tmr_run = state_reg == S_SEL || msg_phase;
  assign tmr_load = state_next != state_reg;
  // Limit follows the state being entered, as loading is on entry
  assign tmr_limit = state_next == S_SEL ? sel_timeout_limit :
    reqack_timeout_limit;

  sscr_timer #(
    .W(TW)
  ) u_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .load(tmr_load),
    .run(tmr_run),
    .limit(tmr_limit),
    .expired(tmo)
  );

  sscr_reporter u_reporter (
    .core_clk(core_clk),
    .resetn(resetn),
    .post(post),
    .code(rep_code),
    .step(rep_step),
    .int_ack(int_ack),
    .int_code_reg(int_code),
    .int_step_reg(int_step),
    .int_req_reg(int_req)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    len_next = len_reg;
    retry_next = retry_reg;
    rx_status_next = rx_status_reg;
    atn_next = atn_reg;
    ack_next = ack_reg;
    data_out_next = data_out_reg;
    msg_index_next = msg_index_reg;
    rx_byte_next = rx_byte_reg;
    rx_wr_next = 1'b0;
    post = 1'b0;
    rep_code = `SSCR_BYTE_ZERO;
    rep_step = `SSCR_BYTE_ZERO;
    if (bus_reset && state_reg != S_IDLE) begin
      // Reset aborts everything; step tells where
      post = 1'b1;
      rep_code = `SSCR_INT_BUS_RESET;
      rep_step = `SSCR_STEP_MSG;
      state_next = S_IDLE;
      atn_next = 1'b0;
      ack_next = 1'b0;
      case (state_reg)
        S_WBF, S_RWAIT: begin
          rep_step = `SSCR_STEP_WAIT_FREE;
        end
        S_ARB: begin
          rep_step = `SSCR_STEP_ARB;
        end
        S_SEL: begin
          rep_step = `SSCR_STEP_SEL;
        end
        default: begin
          rep_step = `SSCR_STEP_MSG;
        end
      endcase
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (cmd_start) begin
            msg_index_next = `SSCR_INDEX_ZERO;
            retry_next = sel_retries;
            atn_next = 1'b0;
            ack_next = 1'b0;
            len_next = cmd_multi ? message_byte_count[5:0] :
              single_msg_len;
            if (resel_pending) begin
              state_next = S_RWAIT;
            end else if (!cmd_multi &&
                single_msg_len > `SSCR_SINGLE_MSG_MAX) begin
              post = 1'b1;
              rep_code = `SSCR_INT_RESEL;
              rep_step = `SSCR_STEP_MSG;
            end else if (cmd_multi &&
                message_byte_count == `SSCR_COUNT_ZERO) begin
              post = 1'b1;
              rep_code = `SSCR_INT_NO_COUNT;
              rep_step = `SSCR_STEP_MSG;
            end else begin
              state_next = S_WBF;
            end
          end
        end
        S_RWAIT: begin
          if (resel_op_done) begin
            post = 1'b1;
            rep_code = `SSCR_INT_RESEL;
            rep_step = `SSCR_STEP_WAIT_FREE;
            state_next = S_IDLE;
          end
        end
        S_WBF: begin
          if (reselected) begin
            post = 1'b1;
            rep_code = `SSCR_INT_RESEL;
            rep_step = `SSCR_STEP_WAIT_FREE;
            state_next = S_IDLE;
          end else if (bus_free) begin
            state_next = S_ARB;
          end
        end
        S_ARB: begin
          if (pause_req) begin
            post = 1'b1;
            rep_code = `SSCR_INT_PAUSE;
            rep_step = `SSCR_STEP_ARB;
            state_next = S_IDLE;
          end else if (arb_won) begin
            atn_next = 1'b1;
            state_next = S_SEL;
          end else if (arb_lost) begin
            state_next = S_WBF;
          end
        end
        S_SEL: begin
          if (sel_bsy) begin
            state_next = S_FREQ;
          end else if (tmo) begin
            atn_next = 1'b0;
            if (retry_reg == `SSCR_RETRY_ZERO) begin
              post = 1'b1;
              rep_code = `SSCR_INT_SEL_TMO;
              rep_step = `SSCR_STEP_SEL;
              state_next = S_IDLE;
            end else begin
              retry_next = retry_reg - `SSCR_RETRY_ONE;
              state_next = S_WBF;
            end
          end
        end
        S_FREQ: begin
          if (bus_free) begin
            post = 1'b1;
            rep_code = `SSCR_INT_NEXUS_FREE;
            rep_step = `SSCR_STEP_MSG;
            atn_next = 1'b0;
            state_next = S_IDLE;
          end else if (tmo) begin
            post = 1'b1;
            rep_code = `SSCR_INT_REQ_TMO;
            rep_step = `SSCR_STEP_MSG;
            atn_next = 1'b0;
            state_next = S_IDLE;
          end else if (req_in) begin
            if (phase_in == `SSCR_PH_MSG_OUT) begin
              data_out_next = msg_byte;
              ack_next = 1'b1;
              atn_next = !last_byte;
              state_next = S_ACK;
            end else if (auto_receive &&
                (phase_in == `SSCR_PH_MSG_IN ||
                phase_in == `SSCR_PH_STATUS)) begin
              atn_next = 1'b0;
              rx_status_next = phase_in == `SSCR_PH_STATUS;
              if (rx_buf_full) begin
                post = 1'b1;
                rep_code = phase_in == `SSCR_PH_STATUS ?
                  `SSCR_INT_STS_SKIP : `SSCR_INT_MSG_SKIP;
                rep_step = `SSCR_STEP_MSG;
                state_next = S_IDLE;
              end else begin
                rx_byte_next = data_in;
                rx_wr_next = 1'b1;
                ack_next = 1'b1;
                state_next = S_RXACK;
              end
            end else begin
              post = 1'b1;
              rep_code = `SSCR_INT_BAD_PHASE;
              rep_step = `SSCR_STEP_MSG;
              state_next = S_IDLE;
            end
          end
        end
        S_MREQ: begin
          if (bus_free) begin
            post = 1'b1;
            rep_code = `SSCR_INT_BUS_FREE;
            rep_step = `SSCR_STEP_MSG;
            atn_next = 1'b0;
            state_next = S_IDLE;
          end else if (tmo) begin
            post = 1'b1;
            rep_code = `SSCR_INT_REQ_TMO;
            rep_step = `SSCR_STEP_MSG;
            atn_next = 1'b0;
            state_next = S_IDLE;
          end else if (req_in) begin
            if (phase_in == `SSCR_PH_MSG_OUT) begin
              data_out_next = msg_byte;
              ack_next = 1'b1;
              atn_next = !last_byte;
              state_next = S_ACK;
            end else begin
              post = 1'b1;
              rep_code = `SSCR_INT_PHASE_CHG;
              rep_step = `SSCR_STEP_MSG;
              atn_next = 1'b0;
              state_next = S_IDLE;
            end
          end
        end
        S_ACK: begin
          if (bus_free) begin
            post = 1'b1;
            rep_code = `SSCR_INT_BUS_FREE;
            rep_step = `SSCR_STEP_MSG;
            atn_next = 1'b0;
            ack_next = 1'b0;
            state_next = S_IDLE;
          end else if (tmo) begin
            post = 1'b1;
            rep_code = `SSCR_INT_REQ_TMO;
            rep_step = `SSCR_STEP_MSG;
            atn_next = 1'b0;
            ack_next = 1'b0;
            state_next = S_IDLE;
          end else if (!req_in) begin
            msg_index_next = msg_index_reg + `SSCR_INDEX_ONE;
            if (!last_byte) begin
              ack_next = 1'b0;
              state_next = S_MREQ;
            end else if (auto_ack_release) begin
              ack_next = 1'b0;
              post = 1'b1;
              rep_code = `SSCR_INT_DONE;
              rep_step = `SSCR_STEP_DONE_AUTO;
              state_next = S_IDLE;
            end else begin
              post = 1'b1;
              rep_code = `SSCR_INT_DONE;
              rep_step = `SSCR_STEP_DONE_MAN;
              state_next = S_HOLD;
            end
          end
        end
        S_RXACK: begin
          if (bus_free || tmo) begin
            post = 1'b1;
            rep_code = bus_free ? `SSCR_INT_BUS_FREE :
              `SSCR_INT_REQ_TMO;
            rep_step = `SSCR_STEP_MSG;
            ack_next = 1'b0;
            state_next = S_IDLE;
          end else if (!req_in) begin
            ack_next = 1'b0;
            post = 1'b1;
            rep_code = rx_status_reg ? `SSCR_INT_STS_RCVD :
              `SSCR_INT_MSG_RCVD;
            rep_step = `SSCR_STEP_MSG;
            state_next = S_IDLE;
          end
        end
        S_HOLD: begin
          // Outcome already reported; only ACK is pending
          if (ack_release || bus_free) begin
            ack_next = 1'b0;
            state_next = S_IDLE;
          end
        end
        default: begin
          state_next = S_IDLE;
          atn_next = 1'b0;
          ack_next = 1'b0;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      len_reg <= `SSCR_INDEX_ZERO;
      retry_reg <= {RW{1'b0}};
      rx_status_reg <= 1'b0;
      atn_reg <= 1'b0;
      ack_reg <= 1'b0;
      data_out_reg <= `SSCR_BYTE_ZERO;
      msg_index_reg <= `SSCR_INDEX_ZERO;
      rx_byte_reg <= `SSCR_BYTE_ZERO;
      rx_wr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      len_reg <= len_next;
      retry_reg <= retry_next;
      rx_status_reg <= rx_status_next;
      atn_reg <= atn_next;
      ack_reg <= ack_next;
      data_out_reg <= data_out_next;
      msg_index_reg <= msg_index_next;
      rx_byte_reg <= rx_byte_next;
      rx_wr_reg <= rx_wr_next;
    end
  end

endmodule

//--- sscr_sequencer_assertions.sv
`timescale 1ns/1ps
module sscr_sequencer_assertions (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Watched inputs
  input wire cmd_start,
  input wire cmd_multi,
  input wire [5:0] single_msg_len,
  input wire [7:0] message_byte_count,
  input wire auto_ack_release,
  input wire pause_req,
  input wire bus_reset,
  input wire int_ack,
  // Watched outputs
  input wire arb_req,
  input wire sel_req,
  input wire atn_reg,
  input wire ack_reg,
  input wire busy,
  input wire [7:0] int_code,
  input wire [7:0] int_step,
  input wire int_req
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  reset_idle_a:
    assert property (busy && bus_reset |=> !busy && !atn_reg && !ack_reg)
    else $error("bus reset left the command running");
  reset_code_a:
    assert property (busy && bus_reset
      |-> ##[1:2] (int_req && int_code == 8'h01))
    else $error("bus reset not reported");
  arb_reset_a:
    assert property (arb_req && bus_reset |-> ##[1:2] (int_step == 8'h01))
    else $error("wrong step for reset in arbitration");
  sel_reset_a:
    assert property (sel_req && bus_reset |-> ##[1:2] (int_step == 8'h02))
    else $error("wrong step for reset in selection");
  long_msg_a:
    assert property (cmd_start && !busy && !cmd_multi && single_msg_len > 6'h20
      |-> ##[1:2] (int_req && int_code == 8'h64 && int_step == 8'h03))
    else $error("long message not refused");
  zero_count_a:
    assert property (cmd_start && !busy && cmd_multi
      && message_byte_count == 8'h00
      |-> ##[1:2] (int_req && int_code == 8'h65 && int_step == 8'h03))
    else $error("zero byte count not refused");
  done_step_a:
    assert property ($rose(int_req) && int_code == 8'h60
      |-> int_step == (auto_ack_release ? 8'h0C : 8'h04)
      && ack_reg == !auto_ack_release)
    else $error("normal end step or final ACK wrong");
  bad_phase_atn_a:
    assert property ($rose(int_req) && int_code == 8'h54 |-> atn_reg)
    else $error("ATN dropped on wrong first phase");
  recv_atn_a:
    assert property ($rose(int_req)
      && int_code inside {8'h55, 8'h56, 8'h5D, 8'h5E} |-> !atn_reg)
    else $error("ATN kept during receive request");
  pause_arb_a:
    assert property (pause_req && arb_req
      |-> ##[1:2] (int_req && int_code == 8'h67 && int_step == 8'h01))
    else $error("pause in arbitration not reported");
  req_hold_a:
    assert property (int_req && !int_ack |=> int_req)
    else $error("interrupt request dropped without acknowledge");
  ack_clear_a:
    assert property (int_req && int_ack && !busy && !cmd_start |=> !int_req)
    else $error("acknowledge did not clear interrupt request");

  cover property ($rose(int_req) && int_code == 8'h60);
  cover property ($rose(int_req) && int_code == 8'h54);
  cover property ($rose(int_req) && int_code == 8'h01);
  cover property ($rose(int_req) && int_code == 8'h64);
endmodule

bind sscr_sequencer sscr_sequencer_assertions i_chk (.*);

//--- sscr_target_model.sv
`timescale 1ns/1ps
module sscr_target_model (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Behaviour chosen by the bench
  input wire [3:0] mode,
  input wire [5:0] nbytes,
  input wire [7:0] rx_val,
  // Initiator side
  input wire arb_req,
  input wire sel_req,
  input wire busy,
  input wire ack_reg,
  output reg arb_won,
  output reg sel_bsy,
  output reg bus_free,
  output reg req_in,
  output reg [2:0] phase_in,
  output reg [7:0] data_in
);
  reg nexus;
  reg [5:0] sent;
  reg [1:0] arb_cnt;
  wire rx_mode = mode == 4'h2 || mode == 4'h3;
  wire req_ok = mode != 4'h6 && mode != 4'h7 &&
    !(mode == 4'h9 && sent != 6'h00);
  wire [2:0] ph = (mode == 4'h1 || (mode == 4'h5 && sent != 6'h00)) ? 3'h0 :
    mode == 4'h2 ? 3'h7 : mode == 4'h3 ? 3'h3 : 3'h6;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {arb_won, sel_bsy, bus_free, req_in, nexus} <= 5'h00;
      phase_in <= 3'h0;
      data_in <= 8'h00;
      sent <= 6'h00;
      arb_cnt <= 2'h0;
    end else begin
      arb_cnt <= arb_req ? arb_cnt + 2'h1 : 2'h0;
      arb_won <= arb_req && arb_cnt == 2'h2 && !arb_won;
      sel_bsy <= nexus;
      bus_free <= mode != 4'h8 && !(arb_req || sel_req || nexus);
      // Undriven data toggles so a stale byte never passes as valid
      data_in <= (nexus && rx_mode) ? rx_val : ~data_in;
      if (sel_req && mode != 4'h4)
        nexus <= 1'b1;
      else if ((!busy && !ack_reg) || (mode == 4'h6 && sel_bsy) ||
          (mode == 4'h9 && sent == 6'h01 && !ack_reg))
        nexus <= 1'b0;
      if (!nexus) begin
        req_in <= 1'b0;
        sent <= 6'h00;
      end else if (req_in && ack_reg) begin
        req_in <= 1'b0;
        sent <= sent + 6'h01;
      end else if (!req_in && !ack_reg && sent < nbytes && req_ok) begin
        req_in <= 1'b1;
        phase_in <= ph;
      end
    end
  end
endmodule

//--- select_msg_completion_reporter_tb.sv
`timescale 1ns/1ps
module select_msg_completion_reporter_tb;
  reg core_clk = 1'b0, resetn = 1'b0, cmd_start = 1'b0, cmd_multi = 1'b0;
  reg auto_receive = 1'b0, auto_ack_release = 1'b0, ack_release = 1'b0;
  reg pause_req = 1'b0, resel_pending = 1'b0, resel_op_done = 1'b0;
  reg bus_reset = 1'b0, rx_buf_full = 1'b0, int_ack = 1'b0, ack_q = 1'b0;
  reg arb_lost = 1'b0, reselected = 1'b0, sel_q = 1'b0;
  reg [5:0] single_msg_len = 6'h00, nbytes = 6'h00;
  reg [7:0] message_byte_count = 8'h00, msg_byte = 8'h00, rx_val = 8'h00;
  reg [15:0] sel_timeout_limit = 16'h0014, reqack_timeout_limit = 16'h0040;
  reg [3:0] sel_retries = 4'h2, mode = 4'h0;
  reg [7:0] mem [0:63];
  reg [15:0] exp_q [$];
  reg [7:0] byte_q [$];
  reg [15:0] e;
  integer miscompares = 0, checks_done = 0, i, k, sel_n = 0;
  wire arb_won, sel_bsy, bus_free, req_in, arb_req, sel_req, atn_reg, ack_reg;
  wire rx_wr_reg, busy, int_req;
  wire [2:0] phase_in;
  wire [5:0] msg_index_reg;
  wire [7:0] data_in, data_out_reg, rx_byte_reg, int_code, int_step;
  wire [5:0] ev = {int_req, ack_reg, sel_req, arb_req, 1'b1, !busy};

  sscr_sequencer i_dut (.*);
  sscr_target_model i_target (.*);

  initial forever #2.5 core_clk = ~core_clk;
  always @(negedge core_clk) msg_byte <= mem[msg_index_reg];

  task check(input [63:0] what, input [15:0] seen, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask

  // --------
  // Result watcher
  // --------
  always @(negedge core_clk) begin
    ack_q <= ack_reg;
    int_ack <= 1'b0;
    if (int_req === 1'b1 && int_ack !== 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 16'hXXXX;
      check("report", {int_code, int_step}, e);
      int_ack <= 1'b1;
    end
    if (ack_reg === 1'b1 && ack_q !== 1'b1 && phase_in == 3'h6) begin
      e = byte_q.size() ? byte_q.pop_front() : 8'hXX;
      check("msg", {8'h00, data_out_reg}, e);
    end
    if (rx_wr_reg === 1'b1) begin
      e = byte_q.size() ? byte_q.pop_front() : 8'hXX;
      check("rx", {8'h00, rx_byte_reg}, e);
    end
    sel_q <= sel_req;
    if (sel_req === 1'b1 && sel_q !== 1'b1)
      sel_n = sel_n + 1;
  end

  task end_of_test;
    begin
      if (exp_q.size() + byte_q.size() != 0) begin
        miscompares = miscompares + 1;
        $display("mismatch leftover exp 0 seen %0d",
          exp_q.size() + byte_q.size());
      end
      if (miscompares == 0 && checks_done > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task wait_for(input [2:0] w);
    integer n;
    begin
      n = 0;
      while (n < 4000 && ev[w] !== 1'b1) begin
        @(negedge core_clk);
        n = n + 1;
      end
      if (n == 4000) begin
        miscompares = miscompares + 1;
        $display("mismatch wait exp %0d seen hang", w);
      end
    end
  endtask

  // --------
  // One command: rst_at 1..4 pulses bus reset in wait, arb, sel, msg
  // --------
  task run(input m, input [7:0] len, input [3:0] md, input [2:0] cfg,
      input [2:0] rst_at, input [15:0] exp);
    reg [7:0] r;
    begin
      r = $urandom;
      sel_n = 0;
      for (i = 0; i < 64; i = i + 1)
        mem[i] = $urandom;
      @(negedge core_clk);
      cmd_multi <= m;
      single_msg_len <= len[5:0];
      message_byte_count <= len;
      {rx_buf_full, auto_receive, auto_ack_release} <= cfg;
      mode <= md;
      nbytes <= (md == 4'h2 || md == 4'h3) ? 6'h01 : len[5:0];
      pause_req <= md == 4'hB;
      resel_pending <= md == 4'hA;
      rx_val <= r;
      exp_q.push_back(exp);
      if (!(m ? len == 8'h00 : len > 8'h20) &&
          (rst_at == 3'h0 || rst_at == 3'h4)) begin
        k = md == 4'h0 ? len : (md == 4'h5 || md == 4'h9);
        for (i = 0; i < k; i = i + 1)
          byte_q.push_back(mem[i]);
        if ((md == 4'h2 || md == 4'h3) && !cfg[2])
          byte_q.push_back(r);
      end
      @(negedge core_clk);
      cmd_start <= 1'b1;
      @(negedge core_clk);
      cmd_start <= 1'b0;
      if (rst_at != 3'h0) begin
        wait_for(rst_at);
        bus_reset <= 1'b1;
        @(negedge core_clk);
        bus_reset <= 1'b0;
      end
      if (md == 4'hA) begin
        repeat (4) @(negedge core_clk);
        resel_op_done <= 1'b1;
        @(negedge core_clk);
        resel_op_done <= 1'b0;
      end
      // Lost arbitration, then reselected while waiting bus free
      if (md == 4'hC) begin
        wait_for(3'h2);
        arb_lost <= 1'b1;
        @(negedge core_clk);
        arb_lost <= 1'b0;
        reselected <= 1'b1;
        @(negedge core_clk);
        reselected <= 1'b0;
      end
      // Manual mode keeps ACK, and busy, until released
      if (!cfg[0])
        wait_for(3'h5);
      ack_release <= !cfg[0];
      @(negedge core_clk);
      ack_release <= 1'b0;
      wait_for(3'h0);
      if (md == 4'h4)
        check("retries", sel_n[15:0], sel_retries + 16'h0001);
      repeat (6) @(negedge core_clk);
    end
  endtask

  initial begin
    k = $urandom(32'hDFCEF94A);
    repeat (2) @(negedge core_clk);
    resetn <= 1'b1;
    run(1'b0, 8'h01, 4'h0, 3'h1, 3'h0, 16'h600C);
    run(1'b0, 8'h20, 4'h0, 3'h1, 3'h0, 16'h600C);
    run(1'b0, 8'h21, 4'h0, 3'h1, 3'h0, 16'h6403);
    run(1'b1, 8'h03, 4'h0, 3'h0, 3'h0, 16'h6004);
    run(1'b1, 8'h00, 4'h0, 3'h1, 3'h0, 16'h6503);
    run(1'b0, 8'h01, 4'h1, 3'h1, 3'h0, 16'h5403);
    run(1'b0, 8'h01, 4'h2, 3'h3, 3'h0, 16'h5503);
    run(1'b0, 8'h01, 4'h3, 3'h3, 3'h0, 16'h5603);
    run(1'b0, 8'h01, 4'h2, 3'h7, 3'h0, 16'h5D03);
    run(1'b0, 8'h01, 4'h3, 3'h7, 3'h0, 16'h5E03);
    run(1'b0, 8'h01, 4'h4, 3'h1, 3'h0, 16'h8202);
    run(1'b1, 8'h03, 4'h5, 3'h1, 3'h0, 16'h3203);
    run(1'b0, 8'h01, 4'h6, 3'h1, 3'h0, 16'h7003);
    run(1'b1, 8'h03, 4'h9, 3'h1, 3'h0, 16'h3103);
    run(1'b0, 8'h01, 4'h7, 3'h1, 3'h0, 16'h2C03);
    run(1'b0, 8'h01, 4'hB, 3'h1, 3'h0, 16'h6701);
    run(1'b0, 8'h01, 4'hA, 3'h1, 3'h0, 16'h6400);
    run(1'b0, 8'h01, 4'hC, 3'h1, 3'h0, 16'h6400);
    run(1'b0, 8'h01, 4'h8, 3'h1, 3'h1, 16'h0100);
    run(1'b0, 8'h01, 4'h0, 3'h1, 3'h2, 16'h0101);
    run(1'b0, 8'h01, 4'h0, 3'h1, 3'h3, 16'h0102);
    run(1'b0, 8'h01, 4'h0, 3'h1, 3'h4, 16'h0103);
    end_of_test;
  end

  // Generous bound: all commands finish within a few thousand cycles
  initial begin
    #200000;
    miscompares = miscompares + 1;
    end_of_test;
  end
endmodule
